// ===== plp_pkg.sv
// Shared constants, register map and carrier types for the PHY low-power block
package plp_pkg;
	// Clock rate
	localparam int CLK_KHZ = 50000;
	localparam int CLK_MHZ = 50;
	// Link pulse interval while asleep on no energy
	localparam int LINK_PULSE_MS = 1000;
	localparam int LINK_PULSE_CYC = LINK_PULSE_MS * CLK_KHZ;
	// Line silence before energy sleep
	localparam int SILENCE_MS = 3000;
	localparam int SILENCE_CYC = SILENCE_MS * CLK_KHZ;
	// Longest wake time out of idle, rounded down
	localparam int WAKE_US = 20;
	localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
	// Refresh interval during idle
	localparam int REFRESH_MS = 20;
	localparam int REFRESH_CYC = REFRESH_MS * CLK_KHZ;
	// Lamp blink half period
	localparam int BLINK_MS = 100;
	localparam int BLINK_CYC = BLINK_MS * CLK_KHZ;
	// Register offsets
	localparam logic [15:0] ADDR_CTRL_TWO = 16'h0015;
	localparam logic [15:0] ADDR_LAMP_ONE = 16'h001B;
	localparam logic [15:0] ADDR_LAMP_TWO = 16'h001C;
	localparam logic [15:0] ADDR_LAMP_THREE = 16'h001D;
	localparam logic [15:0] ADDR_LP_ADV = 16'h8001;
	localparam logic [15:0] ADDR_AUX_CLK = 16'hFF1F;
	// Field positions
	localparam int BIT_SLEEP_STATE = 2;
	localparam int BIT_ENERGY_SLEEP = 3;
	localparam int BIT_ADV_FAST = 1;
	localparam int BIT_LAMP_OVR_EN = 0;
	localparam int BIT_LAMP_OVR_ON = 1;
	localparam int BIT_LAMP_NO_BLINK = 0;
	localparam int BIT_LAMP_INVERT = 0;
	localparam int AUX_SEL_LSB = 0;
	localparam int BIT_LINK_INVERT = 4;
	// Reset values
	localparam logic [15:0] RST_REG = 16'h0000;
	// Auxiliary clock sources
	typedef enum logic [1:0] {AUX_OFF, AUX_FREE125, AUX_REF25, AUX_RECOVERED} plp_aux_sel_t;
	// Configuration straps
	typedef struct packed {
		logic energy_sleep;
		logic lowpower;
	} plp_strap_t;
	// Line and link status from the PHY core
	typedef struct packed {
		logic link_up;
		logic speed_100;
		logic partner_lp_adv;
		logic line_energy;
		logic remote_wake;
		logic activity;
	} plp_line_t;
	// Pulse request on both cable pairs
	typedef struct packed {
		logic pair_zero;
		logic pair_one;
	} plp_pair_t;
endpackage

// ===== plp_interval_timer.sv
// Interval counter that runs only while enabled, giving a one-cycle tick
`timescale 1ns/1ps
module plp_interval_timer import plp_pkg::*; #(
	parameter int COUNT = 1000
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_run,
	output logic o_tick
);
	localparam int W = $clog2(COUNT + 1);
	logic [W-1:0] count; // Cycles since start
	logic [W-1:0] next_count;
	logic tick; // End of interval
	logic next_tick;

	// Count while running; stop clears, so each run starts a whole interval
	always_comb begin
		next_count = count;
		next_tick = 1'b0;
		if (!i_run) begin
			next_count = '0;
		end else if (count == W'(COUNT - 1)) begin
			next_count = '0;
			next_tick = 1'b1;
		end else begin
			next_count = count + W'(1);
		end
	end

	// Register stage
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count <= '0;
			tick <= 1'b0;
		end else begin
			count <= next_count;
			tick <= next_tick;
		end
	end

	assign o_tick = tick;
endmodule

// ===== plp_lamp_drive.sv
// Status lamp level: steady on link, blinking on traffic, software override
`timescale 1ns/1ps
module plp_lamp_drive import plp_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_link_up,
	input wire logic i_activity,
	input wire logic i_blink_tick,
	input wire logic i_no_blink,
	input wire logic i_ovr_en,
	input wire logic i_ovr_on,
	input wire logic i_active_low,
	output logic o_pin
);
	logic act_seen; // Traffic since last blink step
	logic phase; // Blink dark phase
	logic pin; // Registered pin level
	logic next_act_seen;
	logic next_phase;
	logic next_pin;
	logic lit;

	// Stretch short activity into visible blink steps
	always_comb begin
		next_act_seen = act_seen | i_activity;
		next_phase = phase;
		if (i_blink_tick) begin
			next_phase = act_seen & ~phase & ~i_no_blink;
			next_act_seen = i_activity;
		end
		lit = i_ovr_en ? i_ovr_on : (i_link_up & ~phase);
		next_pin = lit ^ i_active_low;
	end

	// Register stage; pin reset level is the dark level for active low
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			act_seen <= 1'b0;
			phase <= 1'b0;
			pin <= 1'b1;
		end else begin
			act_seen <= next_act_seen;
			phase <= next_phase;
			pin <= next_pin;
		end
	end

	assign o_pin = pin;
endmodule

// ===== plp_power_ctrl.sv
// Power state, idle, lamp, link indicator and auxiliary clock control
`timescale 1ns/1ps

module plp_power_ctrl import plp_pkg::*; #(
	parameter int LINK_PULSE_COUNT = LINK_PULSE_CYC,
	parameter int SILENCE_COUNT = SILENCE_CYC,
	parameter int REFRESH_COUNT = REFRESH_CYC,
	parameter int BLINK_COUNT = BLINK_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire plp_strap_t i_strap,
	input wire logic i_lamp_pin_in,
	input wire plp_line_t i_line,
	input wire logic i_soft_pd,
	input wire logic i_mac_lpi_req,
	input wire logic i_frame_active,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [15:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	output logic [15:0] o_reg_rdata,
	output logic o_reg_ack,
	output logic o_lamp_pin_out,
	output logic o_lamp_pin_oe,
	output logic o_link_indicator,
	output logic [1:0] o_aux_clk_sel,
	output logic o_cmu_enable,
	output logic o_clocks_gated,
	output plp_pair_t o_link_pulse,
	output logic o_refresh,
	output logic o_wake_tx,
	output logic o_data_ready,
	output logic o_lowpower_link,
	output logic o_energy_sleep
);
	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	typedef enum logic [1:0] {ST_NORMAL, ST_ENERGY_SLEEP, ST_LPI_SLEEP, ST_LPI_WAKE} plp_state_t;

	plp_state_t state; // Power state
	plp_state_t next_state;
	logic captured; // Straps taken
	logic next_captured;
	plp_strap_t strap; // Latched straps
	plp_strap_t next_strap;
	logic lamp_low; // Sensed lamp polarity
	logic next_lamp_low;
	logic [15:0] ctrl_two; // Sleep enable register
	logic [15:0] lamp_one; // Lamp override
	logic [15:0] lamp_two; // Lamp blink control
	logic [15:0] lamp_three; // Lamp polarity control
	logic [15:0] lp_adv; // Advertisement register
	logic [15:0] aux_clk; // Aux clock and link invert
	logic [15:0] next_ctrl_two;
	logic [15:0] next_lamp_one;
	logic [15:0] next_lamp_two;
	logic [15:0] next_lamp_three;
	logic [15:0] next_lp_adv;
	logic [15:0] next_aux_clk;
	logic [15:0] rdata; // Read answer
	logic [15:0] next_rdata;
	logic ack; // Read answer strobe
	logic next_ack;
	logic link_ind; // Link indicator pin
	logic next_link_ind;
	logic cmu_en; // Multiplier power
	logic next_cmu_en;
	logic gated; // Clock gating
	logic next_gated;
	plp_pair_t pulse; // Sleep link pulse
	plp_pair_t next_pulse;
	logic refresh; // Idle refresh strobe
	logic next_refresh;
	logic wake_tx; // Local wake signalling
	logic next_wake_tx;
	logic wake_local; // Wake started locally
	logic next_wake_local;
	logic ready; // Data path open
	logic next_ready;
	logic lp_link; // Low-power link agreed
	logic next_lp_link;
	logic energy_sleep; // Energy sleep active
	logic next_energy_sleep;
	logic energy_en; // Effective sleep enable
	logic lp_en; // Effective low-power advertise
	logic silence_tick;
	logic pulse_tick;
	logic refresh_tick;
	logic wake_tick;
	logic blink_tick;
	logic lamp_pin;

	////////////////////////////////////////////////////////////////////////////////
	// Strap capture

	// Taken on the first edge after release, never by the reset itself
	always_comb begin
		next_captured = 1'b1;
		next_strap = captured ? strap : i_strap;
		next_lamp_low = captured ? lamp_low : i_lamp_pin_in;
	end

	// Polarity defaults to active low until sensed
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			captured <= 1'b0;
			strap <= '0;
			lamp_low <= 1'b1;
		end else begin
			captured <= next_captured;
			strap <= next_strap;
			lamp_low <= next_lamp_low;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	// Register file stays live in every power state
	always_comb begin
		next_ctrl_two = ctrl_two;
		next_lamp_one = lamp_one;
		next_lamp_two = lamp_two;
		next_lamp_three = lamp_three;
		next_lp_adv = lp_adv;
		next_aux_clk = aux_clk;
		next_rdata = rdata;
		next_ack = i_reg_rd;
		if (i_reg_wr) begin
			unique case (i_reg_addr)
				ADDR_CTRL_TWO: next_ctrl_two = i_reg_wdata;
				ADDR_LAMP_ONE: next_lamp_one = i_reg_wdata;
				ADDR_LAMP_TWO: next_lamp_two = i_reg_wdata;
				ADDR_LAMP_THREE: next_lamp_three = i_reg_wdata;
				ADDR_LP_ADV: next_lp_adv = i_reg_wdata;
				ADDR_AUX_CLK: next_aux_clk = i_reg_wdata;
				default: next_rdata = rdata; // Unmapped write ignored
			endcase
		end
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				// Sleep state bit is read-only and shows live status
				ADDR_CTRL_TWO: begin
					next_rdata = ctrl_two;
					next_rdata[BIT_SLEEP_STATE] = energy_sleep;
				end
				ADDR_LAMP_ONE: next_rdata = lamp_one;
				ADDR_LAMP_TWO: next_rdata = lamp_two;
				ADDR_LAMP_THREE: next_rdata = lamp_three;
				ADDR_LP_ADV: next_rdata = lp_adv;
				ADDR_AUX_CLK: next_rdata = aux_clk;
				default: next_rdata = 16'h0000; // Unmapped reads zero
			endcase
		end
	end

	// Register stage; aux clock resets to off
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_two <= RST_REG;
			lamp_one <= RST_REG;
			lamp_two <= RST_REG;
			lamp_three <= RST_REG;
			lp_adv <= RST_REG;
			aux_clk <= RST_REG;
			rdata <= 16'h0000;
			ack <= 1'b0;
		end else begin
			ctrl_two <= next_ctrl_two;
			lamp_one <= next_lamp_one;
			lamp_two <= next_lamp_two;
			lamp_three <= next_lamp_three;
			lp_adv <= next_lp_adv;
			aux_clk <= next_aux_clk;
			rdata <= next_rdata;
			ack <= next_ack;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Timers

	assign energy_en = strap.energy_sleep | ctrl_two[BIT_ENERGY_SLEEP];
	assign lp_en = strap.lowpower | lp_adv[BIT_ADV_FAST];

	// Silence only counts while a sleep would be legal; any energy restarts it
	plp_interval_timer #(.COUNT(SILENCE_COUNT)) u_silence (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_run(state == ST_NORMAL && energy_en && !i_soft_pd && !i_line.line_energy && !i_line.link_up),
		.o_tick(silence_tick)
	);

	// One-second pulse spacing from the reference clock
	plp_interval_timer #(.COUNT(LINK_PULSE_COUNT)) u_pulse (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_run(state == ST_ENERGY_SLEEP),
		.o_tick(pulse_tick)
	);

	// Refresh spacing in idle
	plp_interval_timer #(.COUNT(REFRESH_COUNT)) u_refresh (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_run(state == ST_LPI_SLEEP),
		.o_tick(refresh_tick)
	);

	// One cycle less so the open data path lands inside the limit
	plp_interval_timer #(.COUNT(WAKE_CYC - 1)) u_wake (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_run(state == ST_LPI_WAKE),
		.o_tick(wake_tick)
	);

	// Blink step
	plp_interval_timer #(.COUNT(BLINK_COUNT)) u_blink (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_run(captured),
		.o_tick(blink_tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Power state machine

	// Next state and registered outputs
	always_comb begin
		next_state = state;
		next_wake_local = wake_local;
		next_lp_link = i_line.link_up & i_line.speed_100 & i_line.partner_lp_adv & lp_en;
		next_pulse = '0;
		next_refresh = 1'b0;
		unique case (state)
			ST_NORMAL: begin
				if (silence_tick) begin
					next_state = ST_ENERGY_SLEEP;
				end else if (lp_link && i_mac_lpi_req && !i_frame_active) begin
					next_state = ST_LPI_SLEEP;
				end
			end
			ST_ENERGY_SLEEP: begin
				next_pulse = '{pair_zero: pulse_tick, pair_one: pulse_tick};
				if (i_line.line_energy || !energy_en || i_soft_pd) begin
					next_state = ST_NORMAL;
				end
			end
			ST_LPI_SLEEP: begin
				next_refresh = refresh_tick;
				if (!lp_link) begin
					next_state = ST_NORMAL;
				end else if (i_line.remote_wake) begin
					next_state = ST_LPI_WAKE;
					next_wake_local = 1'b0;
				end else if (!i_mac_lpi_req) begin
					next_state = ST_LPI_WAKE;
					next_wake_local = 1'b1;
				end
			end
			ST_LPI_WAKE: begin
				if (wake_tick) begin
					next_state = ST_NORMAL;
					next_wake_local = 1'b0;
				end
			end
		endcase
		// Data path only opens in normal state, so no frame straddles a change
		next_ready = (next_state == ST_NORMAL) && captured;
		next_wake_tx = (next_state == ST_LPI_WAKE) && next_wake_local;
		// Strobes only while the sleep holds, so none outlives the state flags
		next_pulse = (next_state == ST_ENERGY_SLEEP) ? next_pulse : '0;
		next_refresh = next_refresh && (next_state == ST_LPI_SLEEP);
		next_energy_sleep = next_state == ST_ENERGY_SLEEP;
		next_gated = next_state == ST_ENERGY_SLEEP || next_state == ST_LPI_SLEEP;
		// Free 125 MHz costs power: multiplier stays up even when asleep
		next_cmu_en = captured && (aux_clk[AUX_SEL_LSB +: 2] == 2'(AUX_FREE125) || !next_gated);
		next_link_ind = i_line.link_up ^ aux_clk[BIT_LINK_INVERT];
	end

	// Register stage
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= ST_NORMAL;
			wake_local <= 1'b0;
			lp_link <= 1'b0;
			pulse <= '0;
			refresh <= 1'b0;
			ready <= 1'b0;
			wake_tx <= 1'b0;
			energy_sleep <= 1'b0;
			gated <= 1'b0;
			cmu_en <= 1'b0;
			link_ind <= 1'b0;
		end else begin
			state <= next_state;
			wake_local <= next_wake_local;
			lp_link <= next_lp_link;
			pulse <= next_pulse;
			refresh <= next_refresh;
			ready <= next_ready;
			wake_tx <= next_wake_tx;
			energy_sleep <= next_energy_sleep;
			gated <= next_gated;
			cmu_en <= next_cmu_en;
			link_ind <= next_link_ind;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Lamp

	// Lamp pin released while straps are sensed, driven afterwards
	plp_lamp_drive u_lamp (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_link_up(i_line.link_up),
		.i_activity(i_line.activity),
		.i_blink_tick(blink_tick),
		.i_no_blink(lamp_two[BIT_LAMP_NO_BLINK]),
		.i_ovr_en(lamp_one[BIT_LAMP_OVR_EN]),
		.i_ovr_on(lamp_one[BIT_LAMP_OVR_ON]),
		.i_active_low(lamp_low ^ lamp_three[BIT_LAMP_INVERT]),
		.o_pin(lamp_pin)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign o_reg_rdata = rdata;
	assign o_reg_ack = ack;
	assign o_lamp_pin_out = lamp_pin;
	assign o_lamp_pin_oe = captured;
	assign o_link_indicator = link_ind;
	assign o_aux_clk_sel = aux_clk[AUX_SEL_LSB +: 2];
	assign o_cmu_enable = cmu_en;
	assign o_clocks_gated = gated;
	assign o_link_pulse = pulse;
	assign o_refresh = refresh;
	assign o_wake_tx = wake_tx;
	assign o_data_ready = ready;
	assign o_lowpower_link = lp_link;
	assign o_energy_sleep = energy_sleep;
endmodule

// ===== plp_power_ctrl_properties.sv
// Port-level checks for the power control block
`timescale 1ns/1ps
module plp_power_ctrl_properties import plp_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire plp_line_t i_line,
	input wire logic i_soft_pd,
	input wire logic i_mac_lpi_req,
	input wire logic i_frame_active,
	input wire logic i_reg_rd,
	input wire logic o_reg_ack,
	input wire logic [1:0] o_aux_clk_sel,
	input wire logic o_cmu_enable,
	input wire logic o_clocks_gated,
	input wire plp_pair_t o_link_pulse,
	input wire logic o_refresh,
	input wire logic o_wake_tx,
	input wire logic o_data_ready,
	input wire logic o_lowpower_link,
	input wire logic o_energy_sleep
);
	default clocking dc @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////////////////////////
	a_read_ack: assert property (i_reg_rd |=> o_reg_ack)
		else $error("read not acknowledged");
	a_ack_cause: assert property (o_reg_ack |-> $past(i_reg_rd))
		else $error("ack without read");
	// Pulses only in sleep, on both pairs together
	a_pulse_pairs: assert property (o_link_pulse != 2'b00 |-> o_link_pulse == 2'b11 && o_energy_sleep)
		else $error("bad link pulse");
	// Depth two: the silence tick is registered before entry
	a_sleep_entry: assert property ($rose(o_energy_sleep) |->
		$past(!i_soft_pd && !i_line.line_energy && !i_line.link_up, 2))
		else $error("sleep entered with line active");
	a_sleep_gates: assert property (o_energy_sleep |-> o_clocks_gated && !o_data_ready)
		else $error("clocks not gated in sleep");
	a_free_cmu: assert property (o_aux_clk_sel == 2'd1 && $stable(o_aux_clk_sel) |-> o_cmu_enable)
		else $error("multiplier off with free clock");
	a_energy_exit: assert property (o_energy_sleep && i_line.line_energy |=> !o_energy_sleep)
		else $error("sleep kept despite energy");
	a_wake_bound: assert property ($rose(o_wake_tx) |-> ##[1:1000] o_data_ready)
		else $error("wake too slow");
	a_idle_entry: assert property ($fell(o_data_ready) && !o_energy_sleep && !i_soft_pd |->
		$past(i_mac_lpi_req && !i_frame_active && o_lowpower_link))
		else $error("idle entered without request");
	a_refresh_idle: assert property (o_refresh |-> !o_data_ready && !o_energy_sleep && o_clocks_gated)
		else $error("refresh outside idle");
	a_lp_cause: assert property (o_lowpower_link |->
		$past(i_line.link_up && i_line.partner_lp_adv && i_line.speed_100))
		else $error("low-power link without partner");
	c_sleep: cover property ($rose(o_energy_sleep));
	c_wake: cover property ($rose(o_wake_tx));
	c_refresh: cover property (o_refresh);
endmodule
bind plp_power_ctrl plp_power_ctrl_properties i_props (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
	.i_line(i_line), .i_soft_pd(i_soft_pd), .i_mac_lpi_req(i_mac_lpi_req),
	.i_frame_active(i_frame_active), .i_reg_rd(i_reg_rd), .o_reg_ack(o_reg_ack),
	.o_aux_clk_sel(o_aux_clk_sel), .o_cmu_enable(o_cmu_enable), .o_clocks_gated(o_clocks_gated),
	.o_link_pulse(o_link_pulse), .o_refresh(o_refresh), .o_wake_tx(o_wake_tx),
	.o_data_ready(o_data_ready), .o_lowpower_link(o_lowpower_link), .o_energy_sleep(o_energy_sleep));

// ===== plp_link_partner.sv
// Far-end link partner and local MAC stand-in
`timescale 1ns/1ps
module plp_link_partner import plp_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_plugged,
	input wire logic i_adv,
	input wire logic i_wake,
	input wire logic i_has_data,
	input wire logic i_lowpower_link,
	input wire logic i_data_ready,
	output plp_line_t o_line,
	output logic o_mac_lpi_req
);
	logic link_q; // Link follows cable a cycle late
	////////////////////////////////////////////////////////////
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			link_q <= 1'b0;
		end else begin
			link_q <= i_plugged;
		end
	end
	// Line view; wake held only until the data path opens
	always_comb begin
		o_line.link_up = link_q;
		o_line.speed_100 = 1'b1;
		o_line.partner_lp_adv = i_adv;
		o_line.line_energy = i_plugged;
		o_line.remote_wake = i_wake && !i_data_ready;
		o_line.activity = i_has_data && i_data_ready;
	end
	// MAC asks for idle only with nothing to send or receive
	assign o_mac_lpi_req = i_lowpower_link && !i_has_data && !i_wake;
endmodule

// ===== tb_top.sv
// Self-checking bench for the power control block
`timescale 1ns/1ps
module tb_top import plp_pkg::*;;
	localparam int SIL = 50;
	localparam int LP = 20;
	localparam int RF = 15;
	logic clk, rst_n, soft_pd, frame, wr, rd, pull, plug, adv, wake, data, prev, saw;
	logic [15:0] addr, wdata, rdata;
	plp_strap_t strap;
	plp_line_t line;
	plp_pair_t pulse;
	logic req, ack, lamp_o, lamp_oe, lamp_w, lind, clock_multiplier_unit, gated, refresh, wtx, rdy, lpl, esl;
	logic [1:0] aux;
	int fail_count, checked, n, k;
	logic [15:0] amap [7] = '{16'h0015, 16'h001B, 16'h001C, 16'h001D, 16'h8001, 16'hFF1F, 16'h1234};
	// Lamp wire: pull resistor wins while the pin is released
	assign lamp_w = lamp_oe ? lamp_o : pull;
	plp_power_ctrl #(.LINK_PULSE_COUNT(LP), .SILENCE_COUNT(SIL), .REFRESH_COUNT(RF), .BLINK_COUNT(4)) i_dut (
		.i_mclk(clk), .i_rst_n(rst_n), .i_strap(strap), .i_lamp_pin_in(lamp_w), .i_line(line),
		.i_soft_pd(soft_pd), .i_mac_lpi_req(req), .i_frame_active(frame), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
		.o_lamp_pin_out(lamp_o), .o_lamp_pin_oe(lamp_oe), .o_link_indicator(lind), .o_aux_clk_sel(aux),
		.o_cmu_enable(clock_multiplier_unit), .o_clocks_gated(gated), .o_link_pulse(pulse), .o_refresh(refresh),
		.o_wake_tx(wtx), .o_data_ready(rdy), .o_lowpower_link(lpl), .o_energy_sleep(esl));
	plp_link_partner i_partner (.i_mclk(clk), .i_rst_n(rst_n), .i_plugged(plug), .i_adv(adv),
		.i_wake(wake), .i_has_data(data), .i_lowpower_link(lpl), .i_data_ready(rdy),
		.o_line(line), .o_mac_lpi_req(req));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	////////////////////////////////////////////////////////////
	// Inputs move 1 ns after the edge
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
		cyc(1);
		wr = 1'b1;
		addr = a;
		wdata = d;
		cyc(1);
		wr = 1'b0;
	endtask
	// Ack and data stand in the cycle after the read edge
	task automatic rd_reg(input logic [15:0] a, input logic [15:0] e);
		cyc(1);
		rd = 1'b1;
		addr = a;
		cyc(1);
		rd = 1'b0;
		chk("ack", 16'h0001, {15'h0, ack});
		chk("rdata", e, rdata);
	endtask
	// Count lamp changes over forty cycles
	task automatic blinks();
		k = 0;
		prev = lamp_o;
		for (n = 0; n < 40; n++) begin
			cyc(1);
			if (lamp_o !== prev) k++;
			prev = lamp_o;
		end
	endtask
	task automatic stop_test();
		$display("errors %0d checks %0d", fail_count, checked);
		if (fail_count == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Watchdog well beyond the few thousand cycles needed
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		stop_test();
	end
	////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hB0C8));
		{rst_n, soft_pd, frame, wr, rd, plug, adv, wake, data} = '0;
		{addr, wdata, fail_count, checked} = '0;
		strap = '0;
		pull = 1'b1;
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		cyc(3);
		chk("oe", 16'h0001, {15'h0, lamp_oe});
		for (k = 0; k < 7; k++) rd_reg(amap[k], 16'h0000);
		chk("lamp", 16'h0001, {15'h0, lamp_o});
		for (k = 0; k < 4; k++) begin
			wr_reg(ADDR_AUX_CLK, k[15:0]);
			cyc(1);
			chk("aux", k[15:0], {14'h0, aux});
		end
		wr_reg(16'h1234, 16'($urandom));
		rd_reg(16'h1234, 16'h0000);
		wr_reg(ADDR_AUX_CLK, 16'h0000);
		// Link up: lamp lit, active low
		plug = 1'b1;
		cyc(4);
		chk("link", 16'h0001, {15'h0, lind});
		chk("lamp", 16'h0000, {15'h0, lamp_o});
		wr_reg(ADDR_AUX_CLK, 16'h0010);
		cyc(2);
		chk("link", 16'h0000, {15'h0, lind});
		wr_reg(ADDR_LAMP_ONE, 16'h0001);
		cyc(2);
		chk("lamp", 16'h0001, {15'h0, lamp_o});
		wr_reg(ADDR_LAMP_ONE, 16'h0003);
		wr_reg(ADDR_LAMP_THREE, 16'h0001);
		cyc(2);
		chk("lamp", 16'h0001, {15'h0, lamp_o});
		wr_reg(ADDR_LAMP_ONE, 16'h0000);
		wr_reg(ADDR_LAMP_THREE, 16'h0000);
		wr_reg(ADDR_AUX_CLK, 16'h0000);
		data = 1'b1;
		blinks();
		chk("blink", 16'h0001, {15'h0, k >= 4});
		wr_reg(ADDR_LAMP_TWO, 16'h0001);
		// Let a blink step pass so a dark phase in flight can end
		cyc(6);
		blinks();
		chk("steady", 16'h0000, k[15:0]);
		data = 1'b0;
		wr_reg(ADDR_LAMP_TWO, 16'h0000);
		// Energy sleep: refused under power-down, then entered
		plug = 1'b0;
		soft_pd = 1'b1;
		wr_reg(ADDR_CTRL_TWO, 16'h0008);
		cyc(SIL + 10);
		chk("sleep", 16'h0000, {15'h0, esl});
		soft_pd = 1'b0;
		for (n = 0; n < SIL + 10 && esl !== 1'b1; n++) cyc(1);
		chk("sleep", 16'h0001, {15'h0, esl});
		chk("cmu", 16'h0000, {15'h0, clock_multiplier_unit});
		for (n = 0; n < LP + 5 && pulse !== 2'b11; n++) cyc(1);
		cyc(1);
		for (n = 1; n < LP + 5 && pulse !== 2'b11; n++) cyc(1);
		chk("gap", 16'(LP), n[15:0]);
		rd_reg(ADDR_CTRL_TWO, 16'h000C);
		wr_reg(ADDR_AUX_CLK, 16'h0001);
		cyc(2);
		chk("cmu", 16'h0001, {15'h0, clock_multiplier_unit});
		plug = 1'b1;
		cyc(3);
		chk("ready", 16'h0001, {15'h0, rdy});
		wr_reg(ADDR_CTRL_TWO, 16'h0000);
		wr_reg(ADDR_AUX_CLK, 16'h0000);
		// Idle refused during a frame, then local and remote wake
		adv = 1'b1;
		frame = 1'b1;
		wr_reg(ADDR_LP_ADV, 16'h0002);
		cyc(6);
		chk("lplink", 16'h0001, {15'h0, lpl});
		chk("ready", 16'h0001, {15'h0, rdy});
		for (k = 0; k < 2; k++) begin
			frame = 1'b0;
			for (n = 0; n < 8 && rdy !== 1'b0; n++) cyc(1);
			chk("idle", 16'h0000, {15'h0, rdy});
			for (n = 0; n < RF + 5 && refresh !== 1'b1; n++) cyc(1);
			chk("refresh", 16'h0001, {15'h0, refresh});
			cyc($urandom_range(1, 30));
			data = (k == 0);
			wake = (k == 1);
			saw = 1'b0;
			for (n = 0; n < 1100 && rdy !== 1'b1; n++) begin
				cyc(1);
				saw |= (wtx === 1'b1);
			end
			// First cycle only carries the cause to the edge that samples it
			chk("wake", 16'h0001, {15'h0, n <= WAKE_CYC + 1});
			chk("wake_tx", {15'h0, k == 0}, {15'h0, saw});
			data = 1'b0;
			wake = 1'b0;
		end
		frame = 1'b1;
		// Random traffic, judged by the checker
		repeat (30) begin
			frame = 1'($urandom);
			data = 1'($urandom);
			cyc($urandom_range(1, 40));
		end
		frame = 1'b1;
		data = 1'b0;
		adv = 1'b0;
		cyc(4);
		chk("lplink", 16'h0000, {15'h0, lpl});
		// Second reset: pulled-down lamp and low-power strap
		rst_n = 1'b0;
		strap.lowpower = 1'b1;
		pull = 1'b0;
		adv = 1'b1;
		cyc(8);
		chk("oe", 16'h0000, {15'h0, lamp_oe});
		rst_n = 1'b1;
		cyc(4);
		chk("lamp", 16'h0001, {15'h0, lamp_o});
		chk("lplink", 16'h0001, {15'h0, lpl});
		stop_test();
	end
endmodule
